// ===== inc/sfc_pkg.sv
// sfc_pkg: constants shared by the serial flash command front end
package sfc_pkg;
  // ----------------------------------------
  // array geometry, bus framing and fifo size
  // ----------------------------------------
  localparam int addr_w = 18;
  localparam logic [1:0] addr_last_byte = 2'h2;
  localparam logic [2:0] bit_last = 3'h7;
  localparam int fifo_width = 26;
  localparam int fifo_depth = 16;
  // ----------------------------------------
  // opcodes
  // ----------------------------------------
  localparam logic [7:0] op_read = 8'h03;
  localparam logic [7:0] op_fast_read = 8'h0b;
  localparam logic [7:0] op_sector_a = 8'h20;
  localparam logic [7:0] op_sector_b = 8'hd7;
  localparam logic [7:0] op_block = 8'hd8;
  localparam logic [7:0] op_chip_a = 8'h60;
  localparam logic [7:0] op_chip_b = 8'hc7;
  localparam logic [7:0] op_program = 8'h02;
  localparam logic [7:0] status_read_cmd = 8'h05;
  localparam logic [7:0] status_write_cmd = 8'h01;
  localparam logic [7:0] write_enable_cmd = 8'h06;
  localparam logic [7:0] write_disable_cmd = 8'h04;
  localparam logic [7:0] identity_read_cmd = 8'hab;
  localparam logic [7:0] wake_cmd = identity_read_cmd;
  localparam logic [7:0] deep_sleep_cmd = 8'hb9;
  // arbitrary identification value
  localparam logic [7:0] device_id = 8'h5a;
  // ----------------------------------------
  // status byte layout and reset values
  // ----------------------------------------
  localparam int st_busy = 0;
  localparam int st_wel = 1;
  localparam int st_level_lo = 2;
  localparam int st_level_hi = 3;
  localparam int st_bottom = 5;
  localparam int st_lock = 7;
  localparam logic protect_reset = 1'h0;
  // ----------------------------------------
  // protected range limits
  // ----------------------------------------
  localparam logic [17:0] top_quarter_base = 18'h30000;
  localparam logic [17:0] top_half_base = 18'h20000;
  localparam logic [17:0] bot_quarter_end = 18'h0ffff;
  localparam logic [17:0] bot_half_end = 18'h1ffff;
  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [7:0] {
    sfc_idle = 8'h01,
    sfc_opcode = 8'h02,
    sfc_addr = 8'h04,
    sfc_dummy = 8'h08,
    sfc_wdata = 8'h10,
    sfc_dout = 8'h20,
    sfc_wait = 8'h40,
    sfc_skip = 8'h80
  } sfc_state_e;
endpackage

// ===== logic/sfc_front_end.sv
// sfc_front_end: spi flash command decoder with program data fifo
`timescale 1ns/1ns
// ----------------------------------------
// program data fifo
// ----------------------------------------
module sfc_fifo #(
  parameter int width = sfc_pkg::fifo_width,
  parameter int depth = sfc_pkg::fifo_depth
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data
);
  localparam int pw = $clog2(depth);
  logic [width-1:0] mem [depth];        // storage
  logic [pw:0] wr_ptr_reg, wr_ptr_next; // extra bit tells full from empty
  logic [pw:0] rd_ptr_reg, rd_ptr_next;
  logic do_wr, do_rd;

  // full when pointers differ only in the wrap bit
  assign in_ready = (wr_ptr_reg[pw] == rd_ptr_reg[pw]) ||
                    (wr_ptr_reg[pw-1:0] != rd_ptr_reg[pw-1:0]);
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data = mem[rd_ptr_reg[pw-1:0]];
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;

  // pointer next values
  always_comb begin
    wr_ptr_next = do_wr ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = do_rd ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  end

  // pointer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr_reg[pw-1:0]] <= in_data;
    end
  end
endmodule

// ----------------------------------------
// command front end
// ----------------------------------------
// Notes on behaviour
// R1: wp low with lock set freezes protection bits
// R2: wp high makes lock bit irrelevant
// R3: levels 00 none, 11 whole array protected
// R4: top select: 01 upper quarter, 10 upper half
// R5: bottom select: 01 lower quarter, 10 lower half
// R6: every bus cycle is eight clocks
// R7: writes need write enable latch first
// R8: chip select fall starts new instruction
// R9: sample input on rising clock, msb first
// R10: host frames instructions with chip select
// R11: early chip select rise abandons instruction; for 02 the code still commits the bytes already complete
// R12: 03 plus address streams read data
// R13: 0b adds dummy byte before data
// R14: read address increments, wraps to zero
// R15: 20 or d7 erase sector by a17..a12
// R16: d8 erases block by a17..a16
// R17: 60 or c7 erase whole array
// R18: 02 accepts one to 256 bytes
// R19: 05 repeats status until deselect
// R20: ab plus address streams id; alone wakes
// R21: address bits above a17 ignored
// R22: 06 sets write latch, 04 clears it
// R23: locked status write ignored completely; the code still clears the write latch
// R24: program into protected range discarded
// R25: unknown opcode ignored until deselect
// R26: protection checked against decoded target address
module sfc_front_end (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // serial pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  // array read port, data one cycle after address
  output logic [17:0] rd_addr,
  input wire logic [7:0] rd_data,
  // array engine state
  input wire logic busy,
  // erase requests
  output logic erase_sector,
  output logic erase_block,
  output logic erase_chip,
  output logic [17:0] erase_addr,
  // program stream {addr, data}
  output logic prog_valid,
  input wire logic prog_ready,
  output logic [25:0] prog_word,
  output logic prog_commit,
  output logic prog_drop,
  // status view
  output logic [7:0] status,
  output logic sleeping
);
  logic rst_s1, rst_n;                   // reset release chain
  logic sck_s1, sck_s2, sck_d;           // pin synchronisers
  logic cs_s1, cs_s2, cs_d;
  logic si_s1, si_s2, wp_s1, wp_s2;
  logic sck_rise, sck_fall, cs_fall, cs_rise;
  sfc_pkg::sfc_state_e state_reg, state_next;
  logic [2:0] bit_reg, bit_next;         // bit within bus cycle
  logic [6:0] sh_reg, sh_next;           // input shifter
  logic [7:0] opc_reg, opc_next;
  logic [1:0] acnt_reg, acnt_next;       // address byte count
  logic [17:0] addr_reg, addr_next;
  logic [7:0] page_reg, page_next;       // low byte within page
  logic wr_ok_reg, wr_ok_next;
  logic got_reg, got_next;               // one full data byte seen
  logic [7:0] sdata_reg, sdata_next;
  logic [2:0] ocnt_reg, ocnt_next;       // output bit count
  logic [6:0] tx_reg, tx_next;
  logic so_reg, so_next, oe_reg, oe_next;
  logic [17:0] ra_reg, ra_next;
  logic lo_reg, lo_next, hi_reg, hi_next;
  logic bot_reg, bot_next, lock_reg, lock_next;
  logic wel_reg, wel_next, sleep_reg, sleep_next;
  logic es_reg, es_next, eb_reg, eb_next, ec_reg, ec_next;
  logic [17:0] ea_reg, ea_next;
  logic pc_reg, pc_next, pd_reg, pd_next;
  logic push, push_ready;
  logic [25:0] push_word;
  logic [7:0] byte_in, stat_byte, nb;
  logic [17:0] a_full;
  logic locked, may_write, aligned;

  // protected range lookup for one target address
  function automatic logic prot_hit(input logic [17:0] a, input logic lo,
                                    input logic hi, input logic bot);
    logic r;
    r = 1'b0;
    case ({hi, lo})
      2'h1: r = bot ? (a <= sfc_pkg::bot_quarter_end)              // R4 R5
                    : (a >= sfc_pkg::top_quarter_base);
      2'h2: r = bot ? (a <= sfc_pkg::bot_half_end)                 // R4 R5
                    : (a >= sfc_pkg::top_half_base);
      2'h3: r = 1'b1;                                              // R3
      default: r = 1'b0;                                           // R3
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // reset release and pin sampling
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // two flops per pin, third stage only for edge detection
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {sck_s1, sck_s2, sck_d} <= 3'h0;
      {cs_s1, cs_s2, cs_d} <= 3'h7;
      {si_s1, si_s2} <= 2'h0;
      {wp_s1, wp_s2} <= 2'h3;
    end else begin
      {sck_s1, sck_s2, sck_d} <= {sck, sck_s1, sck_s2};
      {cs_s1, cs_s2, cs_d} <= {cs_n, cs_s1, cs_s2};
      {si_s1, si_s2} <= {si, si_s1};
      {wp_s1, wp_s2} <= {wp_n, wp_s1};
    end
  end

  assign sck_rise = sck_s2 & ~sck_d & ~cs_s2;   // R9
  assign sck_fall = ~sck_s2 & sck_d & ~cs_s2;
  assign cs_fall = ~cs_s2 & cs_d;
  assign cs_rise = cs_s2 & ~cs_d;
  assign byte_in = {sh_reg, si_s2};            // R9
  assign a_full = {addr_reg[9:0], byte_in};    // R21
  assign locked = ~wp_s2 & lock_reg;           // R1 R2
  assign may_write = wel_reg & ~busy;          // R7
  assign aligned = bit_reg == 3'h0;            // R11

  // status byte view, reserved bits zero
  always_comb begin
    stat_byte = 8'h00;
    stat_byte[sfc_pkg::st_busy] = busy;
    stat_byte[sfc_pkg::st_wel] = wel_reg;
    stat_byte[sfc_pkg::st_level_lo] = lo_reg;
    stat_byte[sfc_pkg::st_level_hi] = hi_reg;
    stat_byte[sfc_pkg::st_bottom] = bot_reg;
    stat_byte[sfc_pkg::st_lock] = lock_reg;
  end

  // next byte to shift out
  always_comb begin
    case (opc_reg)
      sfc_pkg::status_read_cmd: nb = stat_byte;    // R19
      sfc_pkg::identity_read_cmd: nb = sfc_pkg::device_id; // R20
      default: nb = rd_data;                        // R12 R13
    endcase
  end

  // ----------------------------------------
  // instruction sequencer next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    opc_next = opc_reg;
    acnt_next = acnt_reg;
    addr_next = addr_reg;
    page_next = page_reg;
    wr_ok_next = wr_ok_reg;
    got_next = got_reg;
    sdata_next = sdata_reg;
    ocnt_next = ocnt_reg;
    tx_next = tx_reg;
    so_next = so_reg;
    oe_next = oe_reg;
    ra_next = ra_reg;
    lo_next = lo_reg;
    hi_next = hi_reg;
    bot_next = bot_reg;
    lock_next = lock_reg;
    wel_next = wel_reg;
    sleep_next = sleep_reg;
    ea_next = ea_reg;
    {es_next, eb_next, ec_next, pc_next} = 4'h0;
    push = 1'b0;
    push_word = {addr_reg[17:8], page_reg, byte_in};
    if (cs_fall) begin
      // fresh instruction, counters cleared
      state_next = sfc_pkg::sfc_opcode;                           // R8
      bit_next = 3'h0;
      acnt_next = 2'h0;
      got_next = 1'b0;
      ocnt_next = 3'h0;
      oe_next = 1'b0;
    end else if (cs_rise) begin
      // deselect: commit complete instructions, drop the rest
      state_next = sfc_pkg::sfc_idle;                             // R11
      oe_next = 1'b0;
      case (state_reg)
        sfc_pkg::sfc_wait: begin
          if (aligned) begin
            case (opc_reg)
              sfc_pkg::write_enable_cmd: wel_next = 1'b1;        // R22
              sfc_pkg::write_disable_cmd: wel_next = 1'b0;       // R22
              sfc_pkg::deep_sleep_cmd: sleep_next = ~busy;
              sfc_pkg::op_chip_a, sfc_pkg::op_chip_b: begin
                ec_next = may_write & ~lo_reg & ~hi_reg;         // R17 R7
                wel_next = 1'b0;
              end
              sfc_pkg::op_sector_a, sfc_pkg::op_sector_b: begin
                es_next = may_write &
                          ~prot_hit(addr_reg, lo_reg, hi_reg, bot_reg); // R15 R26
                ea_next = {addr_reg[17:12], 12'h000};            // R15
                wel_next = 1'b0;
              end
              sfc_pkg::op_block: begin
                eb_next = may_write &
                          ~prot_hit(addr_reg, lo_reg, hi_reg, bot_reg); // R16 R26
                ea_next = {addr_reg[17:16], 16'h0000};           // R16
                wel_next = 1'b0;
              end
              sfc_pkg::status_write_cmd: begin
                if (may_write && !locked) begin                  // R1 R23
                  lo_next = sdata_reg[sfc_pkg::st_level_lo];
                  hi_next = sdata_reg[sfc_pkg::st_level_hi];
                  bot_next = sdata_reg[sfc_pkg::st_bottom];
                  lock_next = sdata_reg[sfc_pkg::st_lock];
                end
                wel_next = 1'b0;
              end
              default: wel_next = wel_reg;
            endcase
          end
        end
        sfc_pkg::sfc_addr: begin
          // wake code on its own, no address bytes
          if (opc_reg == sfc_pkg::wake_cmd && acnt_reg == 2'h0 && aligned) begin
            sleep_next = 1'b0;                                    // R20
          end
        end
        sfc_pkg::sfc_wdata: begin
          // partial final byte is simply not counted
          if (opc_reg == sfc_pkg::op_program && got_reg) begin
            pc_next = wr_ok_reg;                                  // R18 R24
            wel_next = 1'b0;
          end
        end
        default: wel_next = wel_reg;
      endcase
    end else if (sck_rise) begin
      sh_next = {sh_reg[5:0], si_s2};                             // R9
      bit_next = bit_reg + 3'h1;
      if (bit_reg == sfc_pkg::bit_last) begin                     // R6
        case (state_reg)
          sfc_pkg::sfc_opcode: begin
            opc_next = byte_in;
            if (sleep_reg && byte_in != sfc_pkg::wake_cmd) begin
              state_next = sfc_pkg::sfc_skip;                     // asleep: ignore
            end else begin
              case (byte_in)
                sfc_pkg::op_read, sfc_pkg::op_fast_read, sfc_pkg::op_sector_a,
                sfc_pkg::op_sector_b, sfc_pkg::op_block, sfc_pkg::op_program,
                sfc_pkg::identity_read_cmd: state_next = sfc_pkg::sfc_addr;
                sfc_pkg::status_read_cmd: state_next = sfc_pkg::sfc_dout; // R19
                sfc_pkg::status_write_cmd: state_next = sfc_pkg::sfc_wdata;
                sfc_pkg::write_enable_cmd, sfc_pkg::write_disable_cmd,
                sfc_pkg::op_chip_a, sfc_pkg::op_chip_b,
                sfc_pkg::deep_sleep_cmd: state_next = sfc_pkg::sfc_wait;
                default: state_next = sfc_pkg::sfc_skip;          // R25
              endcase
            end
          end
          sfc_pkg::sfc_addr: begin
            addr_next = a_full;                                   // R21
            acnt_next = acnt_reg + 2'h1;
            if (acnt_reg == sfc_pkg::addr_last_byte) begin
              ra_next = a_full;
              page_next = a_full[7:0];
              wr_ok_next = may_write &
                           ~prot_hit(a_full, lo_reg, hi_reg, bot_reg); // R24 R7
              case (opc_reg)
                sfc_pkg::op_read: state_next = sfc_pkg::sfc_dout;     // R12
                sfc_pkg::op_fast_read: state_next = sfc_pkg::sfc_dummy; // R13
                sfc_pkg::identity_read_cmd: state_next = sfc_pkg::sfc_dout; // R20
                sfc_pkg::op_program: state_next = sfc_pkg::sfc_wdata; // R18
                default: state_next = sfc_pkg::sfc_wait;
              endcase
            end
          end
          sfc_pkg::sfc_dummy: state_next = sfc_pkg::sfc_dout;     // R13
          sfc_pkg::sfc_wdata: begin
            got_next = 1'b1;
            if (opc_reg == sfc_pkg::op_program) begin
              // page offset wraps inside the page
              push = wr_ok_reg;                                   // R24
              page_next = page_reg + 8'h01;
            end else begin
              sdata_next = byte_in;
              state_next = sfc_pkg::sfc_wait;
            end
          end
          default: state_next = state_reg;
        endcase
      end
    end else if (sck_fall && state_reg == sfc_pkg::sfc_dout) begin
      // drive after falling edge; fresh byte every eighth fall
      oe_next = 1'b1;
      ocnt_next = ocnt_reg + 3'h1;
      if (ocnt_reg == 3'h0) begin
        so_next = nb[7];
        tx_next = nb[6:0];
        ra_next = ra_reg + 18'h00001;                             // R14
      end else begin
        so_next = tx_reg[6];
        tx_next = {tx_reg[5:0], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // sequencer and status registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= sfc_pkg::sfc_idle;
      bit_reg <= 3'h0;
      sh_reg <= 7'h00;
      opc_reg <= 8'h00;
      acnt_reg <= 2'h0;
      addr_reg <= 18'h00000;
      page_reg <= 8'h00;
      wr_ok_reg <= 1'b0;
      got_reg <= 1'b0;
      sdata_reg <= 8'h00;
      ocnt_reg <= 3'h0;
      tx_reg <= 7'h00;
      so_reg <= 1'b0;
      oe_reg <= 1'b0;
      ra_reg <= 18'h00000;
      lo_reg <= sfc_pkg::protect_reset;
      hi_reg <= sfc_pkg::protect_reset;
      bot_reg <= sfc_pkg::protect_reset;
      lock_reg <= sfc_pkg::protect_reset;
      wel_reg <= 1'b0;
      sleep_reg <= 1'b0;
      {es_reg, eb_reg, ec_reg, pc_reg, pd_reg} <= 5'h00;
      ea_reg <= 18'h00000;
    end else begin
      state_reg <= state_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      opc_reg <= opc_next;
      acnt_reg <= acnt_next;
      addr_reg <= addr_next;
      page_reg <= page_next;
      wr_ok_reg <= wr_ok_next;
      got_reg <= got_next;
      sdata_reg <= sdata_next;
      ocnt_reg <= ocnt_next;
      tx_reg <= tx_next;
      so_reg <= so_next;
      oe_reg <= oe_next;
      ra_reg <= ra_next;
      lo_reg <= lo_next;
      hi_reg <= hi_next;
      bot_reg <= bot_next;
      lock_reg <= lock_next;
      wel_reg <= wel_next;
      sleep_reg <= sleep_next;
      {es_reg, eb_reg, ec_reg, pc_reg} <= {es_next, eb_next, ec_next, pc_next};
      pd_reg <= pd_next;
      ea_reg <= ea_next;
    end
  end

  // spi cannot be stalled, so a full fifo loses the byte and says so
  assign pd_next = push & ~push_ready;

  // ----------------------------------------
  // program data buffer
  // ----------------------------------------
  sfc_fifo #(
    .width(sfc_pkg::fifo_width),
    .depth(sfc_pkg::fifo_depth)
  ) u_fifo (
    .clk(core_clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(push_word),
    .out_valid(prog_valid),
    .out_ready(prog_ready),
    .out_data(prog_word)
  );

  // outputs
  assign so = so_reg;
  assign so_oe = oe_reg;
  assign rd_addr = ra_reg;
  assign erase_sector = es_reg;
  assign erase_block = eb_reg;
  assign erase_chip = ec_reg;
  assign erase_addr = ea_reg;
  assign prog_commit = pc_reg;
  assign prog_drop = pd_reg;
  assign status = {lock_reg, 1'b0, bot_reg, 1'b0, hi_reg, lo_reg, wel_reg, 1'b0};
  assign sleeping = sleep_reg;
endmodule

// ===== bench/sfc_host_model.sv
// host spi master model for the serial pins of the flash front end
`timescale 1ns/1ns
module sfc_host_model (
  // clock
  input wire logic core_clk,
  // serial pins
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  // mode 0: clock idles low, data line starts low
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // select ahead of the opcode
  task automatic frame_open();
    @(posedge core_clk);
    cs_n <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask
  // deselect after the last bit; released data line shows the inverse
  task automatic frame_close();
    repeat (8) @(posedge core_clk);
    cs_n <= 1'b1;
    si <= ~si;
    repeat (12) @(posedge core_clk);
  endtask
  // nb bits msb first; so sampled mid-cycle, well settled
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input int nb = 8);
    for (int i = 7; i > 7 - nb; i--) begin
      @(posedge core_clk);
      sck <= 1'b0;
      si <= tx[i];
      repeat (7) @(posedge core_clk);
      @(negedge core_clk);
      rx[i] = so;
      @(posedge core_clk);
      sck <= 1'b1;
      repeat (7) @(posedge core_clk);
    end
    @(posedge core_clk);
    sck <= 1'b0;
  endtask
endmodule

// ===== bench/sfc_chk.sv
// checker watching the ports of the command front end
`timescale 1ns/1ns
module sfc_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // pins
  input wire logic cs_n,
  input wire logic wp_n,
  input wire logic so_oe,
  // array requests and status
  input wire logic erase_sector,
  input wire logic erase_block,
  input wire logic erase_chip,
  input wire logic [17:0] erase_addr,
  input wire logic prog_valid,
  input wire logic [25:0] prog_word,
  input wire logic prog_commit,
  input wire logic [7:0] status
);
  // ----------------------------------------
  // protected range from level and select bits
  // ----------------------------------------
  function automatic logic prot(input logic [17:0] a, input logic [7:0] st);
    case (st[3:2])
      2'h1: return st[5] ? (a <= 18'h0ffff) : (a >= 18'h30000);
      2'h2: return st[5] ? (a <= 18'h1ffff) : (a >= 18'h20000);
      default: return st[3];
    endcase
  endfunction
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_oe_off; $rose(cs_n) |-> ##[1:6] !so_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe stuck on");
  property p_sector; erase_sector |=> erase_addr[11:0] == 12'h000 && !prot(erase_addr, status);
  endproperty
  a_sector: assert property (p_sector) else $error("bad sector erase");
  property p_block; erase_block |=> erase_addr[15:0] == 16'h0000 && !prot(erase_addr, status);
  endproperty
  a_block: assert property (p_block) else $error("bad block erase");
  property p_chip; erase_chip |-> status[3:2] == 2'h0; endproperty
  a_chip: assert property (p_chip) else $error("chip erase protected");
  property p_prog; prog_valid |-> !prot(prog_word[25:8], status); endproperty
  a_prog: assert property (p_prog) else $error("protected program");
  property p_lock; status[7] && !wp_n && !$past(wp_n, 4) |=> $stable(status[7:2]); endproperty
  a_lock: assert property (p_lock) else $error("lock broken");
  property p_wel; erase_sector || erase_block || erase_chip |-> !status[1] && $past(status[1]);
  endproperty
  a_wel: assert property (p_wel) else $error("erase without latch");
  property p_commit; erase_sector || erase_chip || prog_commit |-> cs_n && $past(cs_n);
  endproperty
  a_commit: assert property (p_commit) else $error("commit selected");
endmodule
bind sfc_front_end sfc_chk i_chk (.*);

// ===== bench/testbench.sv
// self-checking bench for the serial flash command front end
`timescale 1ns/1ns
module testbench;
  // ----------------------------------------
  // signals and tallies
  // ----------------------------------------
  logic core_clk, nrst, wp_n, busy, sck, cs_n, si, so, so_oe, sleeping;
  logic erase_sector, erase_block, erase_chip, prog_valid, prog_ready, prog_commit, prog_drop;
  logic [17:0] rd_addr, erase_addr;
  logic [7:0] rd_data, status, rx;
  logic [25:0] prog_word;
  logic [25:0] words [$]; // drained program words
  int bad_count, cmp_count, n_sec, n_blk, n_chip, n_commit, n_drop, n_oe, oe_mark;
  sfc_front_end i_dut (.*);
  sfc_host_model i_host (.*);
  // array contents: a fixed scramble of the address
  function automatic logic [7:0] mem_byte(input logic [17:0] a);
    return a[7:0] ^ a[15:8] ^ {6'h00, a[17:16]} ^ 8'h3c;
  endfunction
  // backend answers one cycle late and tallies requests
  always @(posedge core_clk) begin
    rd_data <= mem_byte(rd_addr);
    n_sec += erase_sector;
    n_blk += erase_block;
    n_chip += erase_chip;
    n_commit += prog_commit;
    n_drop += prog_drop;
    n_oe += so_oe;
    if (prog_valid && prog_ready) words.push_back(prog_word);
  end
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // opcode then n argument bytes, top byte first
  task automatic start(input logic [7:0] op, input int n, input logic [31:0] arg);
    i_host.frame_open();
    i_host.xfer(op, rx);
    for (int k = n - 1; k >= 0; k--) i_host.xfer(arg[8*k +: 8], rx);
  endtask
  task automatic send(input logic [7:0] op, input int n = 0, input logic [31:0] arg = 0);
    start(op, n, arg);
    i_host.frame_close();
  endtask
  // write enable frame, then the write command itself
  task automatic wr(input logic [7:0] op, input int n = 0, input logic [31:0] arg = 0);
    send(sfc_pkg::write_enable_cmd);
    send(op, n, arg);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    nrst = 1'b0; wp_n = 1'b1; busy = 1'b0; prog_ready = 1'b1;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge core_clk);
    check(status, 8'h00);
    start(sfc_pkg::op_read, 3, 32'h00fffffe); // top address bits set
    for (int k = 0; k < 3; k++) begin
      i_host.xfer(8'h00, rx);
      check(rx, mem_byte(18'(18'h3fffe + k)));
    end
    i_host.frame_close();
    start(sfc_pkg::op_fast_read, 4, 32'h01234500);
    i_host.xfer(8'h00, rx);
    check(rx, mem_byte(18'h12345));
    i_host.frame_close();
    send(sfc_pkg::write_enable_cmd); check(status, 8'h02);
    send(sfc_pkg::write_disable_cmd); check(status, 8'h00);
    send(sfc_pkg::op_block, 3, 32'h010000); check(n_blk, 0);
    // upper quarter protected: inside refused, just below accepted
    wr(sfc_pkg::status_write_cmd, 1, 32'h04); check(status, 8'h04);
    wr(sfc_pkg::op_sector_a, 3, 32'h031234);
    wr(sfc_pkg::op_sector_b, 3, 32'hc2f7ab);
    check(n_sec, 1); check(erase_addr, 18'h2f000);
    // lower half protected
    wr(sfc_pkg::status_write_cmd, 1, 32'h28);
    wr(sfc_pkg::op_block, 3, 32'h01ffff);
    wr(sfc_pkg::op_block, 3, 32'h02abcd);
    check(n_blk, 1); check(erase_addr, 18'h20000);
    wr(sfc_pkg::op_chip_a); check(n_chip, 0);
    // lock with the pin low, then the pin high overrides
    wr(sfc_pkg::status_write_cmd, 1, 32'h80);
    wp_n <= 1'b0;
    wr(sfc_pkg::status_write_cmd, 1, 32'h0c); check(status, 8'h80);
    wp_n <= 1'b1;
    wr(sfc_pkg::status_write_cmd, 1, 32'h00); check(status, 8'h00);
    wr(sfc_pkg::op_chip_a);
    wr(sfc_pkg::op_chip_b); check(n_chip, 2);
    // deselect in mid byte abandons the erase
    send(sfc_pkg::write_enable_cmd); start(sfc_pkg::op_sector_a, 2, 32'h0100);
    i_host.xfer(8'h00, rx, 5);
    i_host.frame_close();
    check(n_sec, 1); check(status, 8'h02);
    oe_mark = n_oe;
    send(8'hff, 2, 32'h0000); check(n_oe - oe_mark, 0);
    start(sfc_pkg::status_read_cmd, 0, 0);
    repeat (2) begin
      i_host.xfer(8'h00, rx); check(rx, 8'h02);
    end
    i_host.frame_close();
    send(sfc_pkg::deep_sleep_cmd); check(sleeping, 1'b1);
    start(sfc_pkg::identity_read_cmd, 3, 0);
    i_host.xfer(8'h00, rx); check(rx, sfc_pkg::device_id);
    i_host.frame_close();
    send(sfc_pkg::wake_cmd); check(sleeping, 1'b0);
    // program 17 bytes with the backend stalled: one too many for the fifo
    prog_ready <= 1'b0;
    start(sfc_pkg::op_program, 3, 32'h000100);
    for (int k = 0; k < 17; k++) i_host.xfer(8'(k), rx);
    i_host.frame_close();
    check(n_drop, 1); check(n_commit, 1);
    prog_ready <= 1'b1;
    repeat (40) @(posedge core_clk);
    check(words.size(), 16); check(words[0], 26'h0010000); check(words[15], 26'h0010f0f);
    close_out();
  end
  // hang guard, about twice the expected run of some 14000 cycles
  initial begin
    #300000;
    bad_count++;
    close_out();
  end
endmodule
